// >>> hdl/analog_quad_config_latches.sv
// analog quad configuration latches behind the configuration mux port
// assumes fabric logic drives the port synchronously to core_clk (10 MHz);
// gate-on and monitor power inputs come from analog pins and are synchronised
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg_defines.svh"

// Summary of operation
// - four 8-bit latches per quad, port written
// - addresses 1..40 map quad bytes in order
// - latches hold safe defaults after reset
// - bits 2..0 give prescaler scale code
// - bits 4..3 select converter source, 11 invalid
// - bit 5 drives direct input switch
// - bit 6 selects voltage/current pad polarity
// - bit 7 powers prescaler op amp
// - voltage byte bit 4 drives current monitor
// - gate byte bits 3..2 set low current
// - gate byte bit 6 selects gate polarity
// - gate off unless gate-on input high
// - temperature monitor needs bit 0 and control
module analog_quad_config_latches
  import quad_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`ADDR_W-1:0] config_port_address,
  input wire logic [`DATA_W-1:0] config_port_wdata,
  input wire logic config_port_wen,
  input wire logic [`NUM_QUADS-1:0] gate_drive_on_input,
  input wire logic temp_monitor_power_ctl,
  output logic [`DATA_W-1:0] config_port_rdata,
  output logic [`NUM_QUADS-1:0][2:0] voltage_scale,
  output logic [`NUM_QUADS-1:0][2:0] current_scale,
  output logic [`NUM_QUADS-1:0][2:0] temperature_scale,
  output logic [`NUM_QUADS-1:0][1:0] voltage_mux,
  output logic [`NUM_QUADS-1:0][1:0] current_mux,
  output logic [`NUM_QUADS-1:0][1:0] temperature_mux,
  output logic [`NUM_QUADS-1:0][2:0] direct_switch_on,
  output logic [`NUM_QUADS-1:0][1:0] negative_polarity,
  output logic [`NUM_QUADS-1:0][2:0] opamp_operational,
  output logic [`NUM_QUADS-1:0] current_monitor_switch_on,
  output logic [`NUM_QUADS-1:0][1:0] gate_low_current,
  output logic [`NUM_QUADS-1:0] gate_negative_polarity,
  output logic [`NUM_QUADS-1:0][1:0] gate_drive_mode,
  output logic [`NUM_QUADS-1:0] temp_monitor_on
);

  quad_state_t state_ff;
  quad_state_t nxt_state;
  logic rst_n_int;

  assign rst_n_int = state_ff.rst_sync[1];

  // maps a port address onto quad index and byte; only valid with addr_hit
  function automatic logic [5:0] decode_addr(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] off;
    off = a - `QUAD_ADDR_FIRST;
    decode_addr = off[5:0];
  endfunction

  // power-up contents: every latch at its default, every output off
  function automatic quad_state_t default_state();
    quad_state_t s;
    s = '0;
    for (int q = 0; q < `NUM_QUADS; q++) begin
      s.cfg[q][`BYTE_VOLTAGE] = `CH_RESET;
      s.cfg[q][`BYTE_CURRENT] = `CH_RESET;
      s.cfg[q][`BYTE_GATE] = `GATE_RESET;
      s.cfg[q][`BYTE_TEMPERATURE] = `CH_RESET;
    end
    default_state = s;
  endfunction

  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a);
    addr_hit = (a >= `QUAD_ADDR_FIRST) && (a <= `QUAD_ADDR_LAST);
  endfunction

  // channel source decode; the invalid code parks on the prescaler
  function automatic logic [1:0] mux_sel(input logic [`DATA_W-1:0] b);
    logic [1:0] code;
    code = b[`CH_MUX_MSB:`CH_MUX_LSB];
    if (code == 2'h3) begin
      mux_sel = mux_prescaler;
    end else begin
      mux_sel = code;
    end
  endfunction

  always_comb begin
    logic [5:0] idx;
    logic [`DATA_W-1:0] v;
    logic [`DATA_W-1:0] c;
    logic [`DATA_W-1:0] g;
    logic [`DATA_W-1:0] t;
    idx = 6'h00;
    v = '0;
    c = '0;
    g = '0;
    t = '0;
    nxt_state = state_ff;
    nxt_state.rst_sync = {state_ff.rst_sync[0], 1'b1};
    nxt_state.gate_on_meta = gate_drive_on_input;
    nxt_state.gate_on_sync = state_ff.gate_on_meta;
    nxt_state.tmon_meta = temp_monitor_power_ctl;
    nxt_state.tmon_sync = state_ff.tmon_meta;

    idx = decode_addr(config_port_address);
    // write only inside the quad window; other addresses are ignored
    if (config_port_wen && addr_hit(config_port_address)) begin
      nxt_state.cfg[idx[5:2]][idx[1:0]] = config_port_wdata;
    end
    if (addr_hit(config_port_address)) begin
      nxt_state.rd_data = state_ff.cfg[idx[5:2]][idx[1:0]];
    end else begin
      nxt_state.rd_data = 8'h00;
    end

    for (int q = 0; q < `NUM_QUADS; q++) begin
      v = state_ff.cfg[q][`BYTE_VOLTAGE];
      c = state_ff.cfg[q][`BYTE_CURRENT];
      g = state_ff.cfg[q][`BYTE_GATE];
      t = state_ff.cfg[q][`BYTE_TEMPERATURE];
      nxt_state.v_scale[q] = v[`CH_SCALE_MSB:`CH_SCALE_LSB];
      nxt_state.c_scale[q] = c[`CH_SCALE_MSB:`CH_SCALE_LSB];
      // only 000/010 are meaningful here; kept as written
      nxt_state.t_scale[q] = t[`CH_SCALE_MSB:`CH_SCALE_LSB];
      nxt_state.v_mux[q] = mux_sel(v);
      nxt_state.c_mux[q] = mux_sel(c);
      nxt_state.t_mux[q] = mux_sel(t);
      nxt_state.direct_sw[q] = {t[`CH_DIRECT_BIT], c[`CH_DIRECT_BIT],
                                v[`CH_DIRECT_BIT]};
      nxt_state.neg_pol[q] = {c[`CH_POLARITY_BIT],
                              v[`CH_POLARITY_BIT]};
      nxt_state.opamp_on[q] = {t[`CH_OPAMP_BIT], c[`CH_OPAMP_BIT],
                               v[`CH_OPAMP_BIT]};
      nxt_state.curmon_sw[q] = v[`VOLT_CURMON_BIT];
      nxt_state.gate_cur[q] = g[`GATE_CUR_MSB:`GATE_CUR_LSB];
      nxt_state.gate_neg[q] = g[`GATE_POLARITY_BIT];
      // spare gate bits 1,4,5 and temperature bit 6 drive nothing
      if (!state_ff.gate_on_sync[q]) begin
        nxt_state.gate_mode[q] = drive_off;
      end else if (g[`GATE_HIGH_BIT]) begin
        nxt_state.gate_mode[q] = drive_high;
      end else begin
        nxt_state.gate_mode[q] = drive_low;
      end
      // mixed settings are undefined; treated as off to stay safe
      nxt_state.tmon_on[q] = g[`GATE_TMON_BIT] &
                             state_ff.tmon_sync;
    end
    // defaults held until the synchronised reset lets go
    if (!rst_n_int) begin
      nxt_state = default_state();
      nxt_state.rst_sync = {state_ff.rst_sync[0], 1'b1};
    end
  end

  // every latch returns to its default under reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff.rst_sync <= 2'h0;
      for (int q = 0; q < `NUM_QUADS; q++) begin
        state_ff.cfg[q][`BYTE_VOLTAGE] <= `CH_RESET;
        state_ff.cfg[q][`BYTE_CURRENT] <= `CH_RESET;
        state_ff.cfg[q][`BYTE_GATE] <= `GATE_RESET;
        state_ff.cfg[q][`BYTE_TEMPERATURE] <= `CH_RESET;
      end
      state_ff.rd_data <= '0;
      state_ff.gate_on_meta <= '0;
      state_ff.gate_on_sync <= '0;
      state_ff.tmon_meta <= 1'b0;
      state_ff.tmon_sync <= 1'b0;
      state_ff.v_scale <= '0;
      state_ff.c_scale <= '0;
      state_ff.t_scale <= '0;
      state_ff.v_mux <= '0;
      state_ff.c_mux <= '0;
      state_ff.t_mux <= '0;
      state_ff.direct_sw <= '0;
      state_ff.neg_pol <= '0;
      state_ff.opamp_on <= '0;
      state_ff.curmon_sw <= '0;
      state_ff.gate_cur <= '0;
      state_ff.gate_neg <= '0;
      state_ff.gate_mode <= '0;
      state_ff.tmon_on <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign config_port_rdata = state_ff.rd_data;
  assign voltage_scale = state_ff.v_scale;
  assign current_scale = state_ff.c_scale;
  assign temperature_scale = state_ff.t_scale;
  assign voltage_mux = state_ff.v_mux;
  assign current_mux = state_ff.c_mux;
  assign temperature_mux = state_ff.t_mux;
  assign direct_switch_on = state_ff.direct_sw;
  assign negative_polarity = state_ff.neg_pol;
  assign opamp_operational = state_ff.opamp_on;
  assign current_monitor_switch_on = state_ff.curmon_sw;
  assign gate_low_current = state_ff.gate_cur;
  assign gate_negative_polarity = state_ff.gate_neg;
  assign gate_drive_mode = state_ff.gate_mode;
  assign temp_monitor_on = state_ff.tmon_on;

endmodule // analog_quad_config_latches

`default_nettype wire

// >>> hdl/quad_cfg_defines.svh
// quad configuration latch constants: addresses, field positions, resets
// assumes inclusion by bare name from the package and the design module
`ifndef QUAD_CFG_DEFINES_SVH
`define QUAD_CFG_DEFINES_SVH

`define NUM_QUADS 10
`define ADDR_W 8
`define DATA_W 8
`define QUAD_ADDR_FIRST 8'h01
`define QUAD_ADDR_LAST 8'h28
`define BYTE_VOLTAGE 2'h0
`define BYTE_CURRENT 2'h1
`define BYTE_GATE 2'h2
`define BYTE_TEMPERATURE 2'h3

// channel byte fields
`define CH_SCALE_LSB 0
`define CH_SCALE_MSB 2
`define CH_MUX_LSB 3
`define CH_MUX_MSB 4
`define CH_DIRECT_BIT 5
`define CH_POLARITY_BIT 6
`define CH_OPAMP_BIT 7
`define VOLT_CURMON_BIT 4

// gate driver byte fields
`define GATE_TMON_BIT 0
`define GATE_CUR_LSB 2
`define GATE_CUR_MSB 3
`define GATE_POLARITY_BIT 6
`define GATE_HIGH_BIT 7

// defaults: scale 000 (16 V), mux prescaler, all off, positive, op amp down
`define CH_RESET 8'h00
`define GATE_RESET 8'h00

`endif

// >>> hdl/quad_cfg_pkg.sv
// types for the analog quad configuration latches
// assumes quad_cfg_defines.svh is on the include path
`include "quad_cfg_defines.svh"

package quad_cfg_pkg;

  typedef enum logic [1:0] {
    mux_prescaler,
    mux_direct,
    mux_monitor,
    mux_invalid
  } adc_mux_t;

  typedef enum logic [1:0] {
    drive_off,
    drive_low,
    drive_high
  } gate_mode_t;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [`NUM_QUADS-1:0][3:0][`DATA_W-1:0] cfg;
    logic [`DATA_W-1:0] rd_data;
    logic [`NUM_QUADS-1:0] gate_on_meta;
    logic [`NUM_QUADS-1:0] gate_on_sync;
    logic tmon_meta;
    logic tmon_sync;
    logic [`NUM_QUADS-1:0][2:0] v_scale;
    logic [`NUM_QUADS-1:0][2:0] c_scale;
    logic [`NUM_QUADS-1:0][2:0] t_scale;
    logic [`NUM_QUADS-1:0][1:0] v_mux;
    logic [`NUM_QUADS-1:0][1:0] c_mux;
    logic [`NUM_QUADS-1:0][1:0] t_mux;
    logic [`NUM_QUADS-1:0][2:0] direct_sw;
    logic [`NUM_QUADS-1:0][1:0] neg_pol;
    logic [`NUM_QUADS-1:0][2:0] opamp_on;
    logic [`NUM_QUADS-1:0] curmon_sw;
    logic [`NUM_QUADS-1:0][1:0] gate_cur;
    logic [`NUM_QUADS-1:0] gate_neg;
    logic [`NUM_QUADS-1:0][1:0] gate_mode;
    logic [`NUM_QUADS-1:0] tmon_on;
  } quad_state_t;

endpackage : quad_cfg_pkg

// >>> verif/cfg_fabric_model.sv
// fabric logic model driving the configuration mux port
// assumes one core_clk; drives 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg_defines.svh"
module cfg_fabric_model (
  input wire logic core_clk,
  input wire logic [`DATA_W-1:0] config_port_rdata,
  output var logic [`ADDR_W-1:0] config_port_address,
  output var logic [`DATA_W-1:0] config_port_wdata,
  output var logic config_port_wen
);
  initial begin
    config_port_address = 8'h00;
    config_port_wdata = 8'h00;
    config_port_wen = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a[1:0] == 2'b00) begin
      v[6] = 1'b0;
      v[2:0] = v[2:0] & 3'b010;
    end
    if (a[1:0] == 2'b11) begin
      v = v & 8'hcd;
    end
    if (v[4:3] == 2'b11) begin
      v[4] = 1'b0;
    end
    @(posedge core_clk);
    #1;
    config_port_address = a;
    config_port_wdata = v;
    config_port_wen = 1'b1;
    @(posedge core_clk);
    #1;
    config_port_wen = 1'b0;
    // stale data is inverted so nothing leans on a held value
    config_port_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    config_port_address = a;
    @(posedge core_clk);
    #1;
    d = config_port_rdata;
  endtask
endmodule // cfg_fabric_model
`default_nettype wire

// >>> verif/quad_cfg_properties.sv
// checker for the analog quad configuration latches, watching top ports
// assumes binding onto analog_quad_config_latches; one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg_defines.svh"
module quad_cfg_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [`ADDR_W-1:0] config_port_address,
  input wire logic [`DATA_W-1:0] config_port_wdata,
  input wire logic config_port_wen,
  input wire logic [`NUM_QUADS-1:0] gate_drive_on_input,
  input wire logic temp_monitor_power_ctl,
  input wire logic [`DATA_W-1:0] config_port_rdata,
  input wire logic [`NUM_QUADS-1:0][2:0] voltage_scale,
  input wire logic [`NUM_QUADS-1:0][1:0] current_mux,
  input wire logic [`NUM_QUADS-1:0][2:0] direct_switch_on,
  input wire logic [`NUM_QUADS-1:0][1:0] negative_polarity,
  input wire logic [`NUM_QUADS-1:0][2:0] opamp_operational,
  input wire logic [`NUM_QUADS-1:0] current_monitor_switch_on,
  input wire logic [`NUM_QUADS-1:0][1:0] gate_low_current,
  input wire logic [`NUM_QUADS-1:0][1:0] gate_drive_mode,
  input wire logic [`NUM_QUADS-1:0] temp_monitor_on
);
  // writes count only once the synchronised reset has let go
  logic [1:0] age_ff;
  logic [`ADDR_W-1:0] wa;
  assign wa = (age_ff[1] && config_port_wen) ? config_port_address : 8'h00;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      age_ff <= 2'd0;
    end else if (!age_ff[1]) begin
      age_ff <= age_ff + 2'd1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  scale_code_a: assert property (wa == 8'h01 |-> ##2
    voltage_scale[0] == $past(config_port_wdata[2:0], 2))
    else $error("voltage scale differs from written code");
  op_amp_a: assert property (wa == 8'h01 |-> ##2
    opamp_operational[0][0] == $past(config_port_wdata[7], 2))
    else $error("op amp mode differs from written bit");
  cur_monitor_a: assert property (wa == 8'h01 |-> ##2
    current_monitor_switch_on[0] == $past(config_port_wdata[4], 2))
    else $error("current monitor switch wrong");
  mux_sel_a: assert property (wa == 8'h26 && config_port_wdata[4:3] != 2'b11
    |-> ##2 current_mux[9] == $past(config_port_wdata[4:3], 2))
    else $error("mux select wrong");
  direct_sw_a: assert property (wa == 8'h26 |-> ##2
    direct_switch_on[9][1] == $past(config_port_wdata[5], 2))
    else $error("direct switch wrong");
  pad_polarity_a: assert property (wa == 8'h26 |-> ##2
    negative_polarity[9][1] == $past(config_port_wdata[6], 2))
    else $error("pad polarity wrong");
  gate_current_a: assert property (wa == 8'h03 |-> ##2
    gate_low_current[0] == $past(config_port_wdata[3:2], 2))
    else $error("gate low current wrong");
  gate_off_a: assert property (!gate_drive_on_input[0] [*4]
    |-> gate_drive_mode[0] == 2'd0)
    else $error("gate driver on while gate-on input low");
  temp_mon_a: assert property (temp_monitor_on[0]
    |-> $past(temp_monitor_power_ctl, 3))
    else $error("temperature monitor on without control");
  reset_default_a: assert property ($rose(reset_n) |->
    voltage_scale == '0 && gate_drive_mode == '0 && config_port_rdata == '0)
    else $error("outputs not at defaults after reset");
  unmapped_read_a: assert property (!config_port_wen &&
    config_port_address == 8'h29 |=> config_port_rdata == 8'h00)
    else $error("unmapped address read not zero");
endmodule // quad_cfg_properties
bind analog_quad_config_latches quad_cfg_properties chk_u (.*);
`default_nettype wire

// >>> verif/tb_analog_quad_config_latches.sv
// self-checking bench for the analog quad configuration latches
// assumes the fabric model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "quad_cfg_defines.svh"
module tb_analog_quad_config_latches;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [`NUM_QUADS-1:0] gate_drive_on_input = '0;
  logic temp_monitor_power_ctl = 1'b0;
  logic [`ADDR_W-1:0] config_port_address;
  logic [`DATA_W-1:0] config_port_wdata;
  logic [`DATA_W-1:0] config_port_rdata;
  logic config_port_wen;
  logic [`NUM_QUADS-1:0][2:0] voltage_scale, direct_switch_on;
  logic [`NUM_QUADS-1:0][2:0] opamp_operational;
  logic [`NUM_QUADS-1:0][1:0] current_mux, negative_polarity;
  logic [`NUM_QUADS-1:0][1:0] gate_low_current, gate_drive_mode;
  logic [`NUM_QUADS-1:0] current_monitor_switch_on, gate_negative_polarity;
  logic [`NUM_QUADS-1:0] temp_monitor_on;
  logic [`NUM_QUADS-1:0][2:0] current_scale, temperature_scale;
  logic [`NUM_QUADS-1:0][1:0] voltage_mux, temperature_mux;
  int failures = 0;
  int compares = 0;
  logic [7:0] rv;
  analog_quad_config_latches dut_u (.*);
  cfg_fabric_model fab_u (.*);
  always #50 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    cyc(3);
    reset_n = 1'b1;
    cyc(3);
  endtask
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    final_report();
  end
  initial begin
    do_reset();
    for (int a = 1; a <= 40; a++) begin
      fab_u.rd(8'(a), rv);
      chk("reset byte", 8'h00, rv);
    end
    $display("test defaults done");
    for (int c = 0; c < 8; c++) begin
      fab_u.wr(8'h01, 8'h80 | 8'(c));
      cyc(1);
      chk("scale", 8'(c), 8'(voltage_scale[0]));
      chk("op amp", 8'h01, 8'(opamp_operational[0][0]));
    end
    fab_u.rd(8'h01, rv);
    chk("readback", 8'h87, rv);
    fab_u.wr(8'h01, 8'h10);
    cyc(1);
    chk("cur monitor", 8'h01, 8'(current_monitor_switch_on[0]));
    chk("volt mux", 8'h02, 8'(voltage_mux[0]));
    chk("op amp off", 8'h00, 8'(opamp_operational[0][0]));
    $display("test voltage byte done");
    for (int m = 0; m < 3; m++) begin
      fab_u.wr(8'h26, 8'h60 | 8'(m << 3));
      cyc(1);
      chk("mux", 8'(m), 8'(current_mux[9]));
      chk("cur scale", 8'h00, 8'(current_scale[9]));
      chk("direct", 8'h01, 8'(direct_switch_on[9][1]));
      chk("polarity", 8'h01, 8'(negative_polarity[9][1]));
    end
    fab_u.wr(8'h28, 8'hff);
    fab_u.rd(8'h28, rv);
    chk("last byte", 8'haa, rv);
    chk("temp direct", 8'h01, 8'(direct_switch_on[9][2]));
    chk("temp scale", 8'h02, 8'(temperature_scale[9]));
    chk("temp mux", 8'h01, 8'(temperature_mux[9]));
    fab_u.wr(8'h29, 8'hff);
    fab_u.wr(8'h00, 8'hff);
    fab_u.rd(8'h29, rv);
    chk("unmapped", 8'h00, rv);
    fab_u.rd(8'h01, rv);
    chk("kept byte", 8'h10, rv);
    $display("test channel bytes done");
    gate_drive_on_input = 10'h001;
    temp_monitor_power_ctl = 1'b1;
    for (int i = 0; i < 4; i++) begin
      fab_u.wr(8'h03, 8'hc1 | 8'(i << 2));
      cyc(1);
      chk("gate current", 8'(i), 8'(gate_low_current[0]));
      chk("gate pol", 8'h01, 8'(gate_negative_polarity[0]));
      chk("high drive", 8'h02, 8'(gate_drive_mode[0]));
    end
    chk("tmon on", 8'h01, 8'(temp_monitor_on[0]));
    gate_drive_on_input = 10'h000;
    temp_monitor_power_ctl = 1'b0;
    cyc(3);
    chk("gate off", 8'h00, 8'(gate_drive_mode[0]));
    chk("tmon off", 8'h00, 8'(temp_monitor_on[0]));
    gate_drive_on_input = 10'h001;
    fab_u.wr(8'h03, 8'h01);
    cyc(1);
    chk("low drive", 8'h01, 8'(gate_drive_mode[0]));
    chk("tmon mixed", 8'h00, 8'(temp_monitor_on[0]));
    $display("test gate byte done");
    do_reset();
    fab_u.rd(8'h03, rv);
    chk("reset again", 8'h00, rv);
    chk("scale reset", 8'h00, 8'(voltage_scale[0]));
    $display("test mid-run reset done");
    final_report();
  end
endmodule // tb_analog_quad_config_latches
`default_nettype wire
